// File: hdl/clock_generator_pll_prescalers.sv
// clock generator: oscillator selection, x4 multiplier, prescalers, axi4-lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "clkgen_consts.svh"
module clock_generator_pll_prescalers #(
  parameter int LOCK_CYCLES  = `PLL_LOCK_CYCLES,
  parameter int MAIN_OSC_HZ  = `MAIN_OSC_MAX_HZ
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output clkgen_pkg::axi_resp_t      s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output clkgen_pkg::axi_resp_t      s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // resonator pins and option strap
  input  wire logic                  main_osc_pin,
  input  wire logic                  sub_osc_pin,
  input  wire logic                  sub_osc_rc_option,
  // power modes from the same clock domain
  input  wire logic                  stop_mode,
  input  wire logic                  halt_mode,
  // oscillator control
  output logic                       main_osc_stop,
  // clock enables
  output logic                       main_clk_en,
  output logic                       cpu_clk_en,
  output logic                       sys_clk_en,
  output logic [10:0]                periph_clk_en,
  output logic                       watch_clk_en,
  output logic [10:0]                wdt_clk_en,
  output logic                       int_osc_en,
  // clock output pin
  output logic                       system_clock_output_pin,
  output logic                       system_clock_output_oe
);
  import clkgen_pkg::*;

  logic [2:0]  div_sel;
  logic        sub_sel;
  logic        main_osc_stop_bit;
  logic        clock_source_status_bit;
  logic        multiplier_run_bit;
  logic        multiplier_path_select;
  logic        multiply_enable_bit;
  logic        system_clock_output_pin_enable;
  logic [2:0]  active_div;
  pll_state_t  pll_state;
  logic [31:0] lock_cnt;
  logic [2:0]  main_sync;
  logic [2:0]  sub_sync;
  logic [1:0]  rc_sync;
  logic        osc_en;
  logic        sub_en;
  logic [7:0]  osc_cnt;
  logic [7:0]  osc_period;
  logic [5:0]  quarter;
  logic        pll_pulse;
  logic        pll_use;
  logic        path_pll;
  logic        fxx_en;
  logic [9:0]  p1_cnt;
  logic [9:0]  p4_cnt;
  logic        sys_pulse;
  logic [22:0] watch_acc;
  logic [22:0] next_watch_acc;
  logic [9:0]  int_cnt;
  logic [7:0]  aw_addr;
  logic [7:0]  w_data;
  logic        w_lane0;
  logic        wr_commit;

  function automatic logic low_ones(input logic [9:0] c, input logic [3:0] k);
    logic [9:0] m;
    m = 10'((11'h001 << k) - 11'h001);
    return (c & m) == m;
  endfunction

  // ---------------- pin synchronisers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_sync <= 3'h0;
      sub_sync  <= 3'h0;
      rc_sync   <= 2'h0;
    end else begin
      main_sync <= {main_sync[1:0], main_osc_pin};
      sub_sync  <= {sub_sync[1:0], sub_osc_pin};
      rc_sync   <= {rc_sync[0], sub_osc_rc_option};
    end
  end
  // a stopped resonator gives no edges even if the pin floats
  assign osc_en = main_sync[1] & ~main_sync[2] & ~main_osc_stop;
  assign sub_en = sub_sync[1] & ~sub_sync[2];

  // ---------------- axi4-lite write channel ----------------
  assign wr_commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
      end
      if (wr_commit) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `OFS_PROC_CLK_CTRL, `OFS_MULT_CTRL, `OFS_CLK_DIV_CTRL,
          `OFS_CLK_STATUS, `OFS_CLK_OUT_CTRL: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // software-written control bits; status bits ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_sel                <= 3'(`RST_PROC_CLK_CTRL);
      sub_sel                <= 1'b0;
      main_osc_stop_bit      <= 1'b0;
      multiplier_run_bit     <= 1'b1;
      multiplier_path_select <= 1'b0;
      multiply_enable_bit    <= 1'b0;
      system_clock_output_pin_enable          <= 1'b0;
    end else if (wr_commit && w_lane0) begin
      case (aw_addr)
        `OFS_PROC_CLK_CTRL: begin
          div_sel           <= w_data[`PROC_DIV_LSB+:3];
          sub_sel           <= w_data[`PROC_SUB_BIT];
          main_osc_stop_bit <= w_data[`PROC_STOP_BIT];
        end
        `OFS_MULT_CTRL: begin
          multiplier_run_bit     <= w_data[`MULT_RUN_BIT];
          multiplier_path_select <= w_data[`MULT_PATH_BIT];
        end
        `OFS_CLK_DIV_CTRL: multiply_enable_bit <= w_data[0];
        `OFS_CLK_OUT_CTRL: system_clock_output_pin_enable       <= w_data[0];
        default: ;
      endcase
    end
  end

  // ---------------- axi4-lite read channel ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr)
        `OFS_PROC_CLK_CTRL: s_axi_rdata <= {25'h0, main_osc_stop_bit, 1'b0,
                                            clock_source_status_bit, sub_sel, div_sel};
        `OFS_MULT_CTRL:     s_axi_rdata <= {30'h0, multiplier_path_select,
                                            multiplier_run_bit};
        `OFS_CLK_DIV_CTRL:  s_axi_rdata <= {31'h0, multiply_enable_bit};
        `OFS_CLK_STATUS:    s_axi_rdata <= {28'h0, main_osc_stop, pll_state == PLL_LOCKED,
                                            rc_sync[1], clock_source_status_bit};
        `OFS_CLK_OUT_CTRL:  s_axi_rdata <= {31'h0, system_clock_output_pin_enable};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- oscillator stop and source status ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_osc_stop           <= 1'b0;
      clock_source_status_bit <= 1'b0;
    end else begin
      // stop bit only counts once the subclock has taken over
      main_osc_stop <= stop_mode | (main_osc_stop_bit & clock_source_status_bit);
      // source changes land on a subclock edge, so no period is cut short
      if (sub_en)
        clock_source_status_bit <= sub_sel;
    end
  end

  // ---------------- multiplier ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_state <= PLL_OFF;
      lock_cnt  <= 32'h0000_0000;
    end else if (!multiplier_run_bit || main_osc_stop) begin
      pll_state <= PLL_OFF;
      lock_cnt  <= 32'h0000_0000;
    end else begin
      case (pll_state)
        PLL_OFF:     pll_state <= PLL_LOCKING;
        PLL_LOCKING: begin
          lock_cnt <= lock_cnt + 32'h0000_0001;
          if (lock_cnt >= 32'(LOCK_CYCLES - 1))
            pll_state <= PLL_LOCKED;
        end
        PLL_LOCKED:  pll_state <= PLL_LOCKED;
        default:     pll_state <= PLL_OFF;
      endcase
    end
  end

  // measure the oscillator period; four evenly spaced pulses per period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt    <= 8'h00;
      osc_period <= 8'h00;
    end else if (osc_en) begin
      osc_cnt    <= 8'h01;
      osc_period <= osc_cnt;
    end else if (osc_cnt != 8'hFF) begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end
  assign quarter   = osc_period[7:2];
  assign pll_pulse = osc_en | ((quarter != 6'h00) &&
                     (osc_cnt == {2'h0, quarter} || osc_cnt == {1'b0, quarter, 1'b0} ||
                      osc_cnt == 8'({quarter, 1'b0} + {2'h0, quarter})));
  assign pll_use   = multiplier_path_select & multiply_enable_bit &
                     (pll_state == PLL_LOCKED);

  // the path joins the PLL only on an oscillator edge, where both paths pulse together; it leaves as soon as pll_use drops
  always_ff @(posedge aclk) begin
    if (!aresetn)
      path_pll <= 1'b0;
    else if (osc_en)
      path_pll <= pll_use;
  end
  assign fxx_en = (path_pll && pll_use) ? pll_pulse : osc_en;

  // ---------------- prescalers ----------------
  // prescaler two shares the low five bits of prescaler one's counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_cnt     <= 10'h000;
      p4_cnt     <= 10'h000;
      active_div <= 3'h3;
    end else begin
      if (fxx_en) begin
        p1_cnt <= p1_cnt + 10'h001;
        // divider changes wait for the /32 boundary: every ratio is aligned there
        if (p1_cnt[4:0] == 5'h1F)
          active_div <= (div_sel > `MAX_DIV_SEL) ? `MAX_DIV_SEL : div_sel;
      end
      if (osc_en)
        p4_cnt <= p4_cnt + 10'h001;
    end
  end

  assign sys_pulse = clock_source_status_bit ? sub_en :
                     (fxx_en && low_ones(p1_cnt, {1'b0, active_div}));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_clk_en   <= 1'b0;
      periph_clk_en <= 11'h000;
      wdt_clk_en    <= 11'h000;
      sys_clk_en    <= 1'b0;
      cpu_clk_en    <= 1'b0;
    end else begin
      main_clk_en <= fxx_en;
      for (int k = 0; k <= 10; k++) begin
        periph_clk_en[k] <= fxx_en && low_ones(p1_cnt, 4'(k));
        wdt_clk_en[k]    <= osc_en && low_ones(p4_cnt, 4'(k));
      end
      sys_clk_en <= sys_pulse && !stop_mode;
      cpu_clk_en <= sys_pulse && !stop_mode && !halt_mode;
    end
  end

  // fractional divider: exact 32.768 kHz average when the main oscillator runs at MAIN_OSC_HZ
  assign next_watch_acc = watch_acc + 23'(`WATCH_HZ);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watch_acc    <= 23'h00_0000;
      watch_clk_en <= 1'b0;
    end else begin
      watch_clk_en <= 1'b0;
      if (osc_en) begin
        if (next_watch_acc >= 23'(MAIN_OSC_HZ)) begin
          watch_acc    <= next_watch_acc - 23'(MAIN_OSC_HZ);
          watch_clk_en <= 1'b1;
        end else begin
          watch_acc <= next_watch_acc;
        end
      end
    end
  end

  // internal oscillator, free of both resonators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_cnt    <= 10'h000;
      int_osc_en <= 1'b0;
    end else begin
      int_osc_en <= (int_cnt == 10'(`INT_OSC_CYCLES - 1));
      int_cnt    <= (int_cnt == 10'(`INT_OSC_CYCLES - 1)) ? 10'h000 : int_cnt + 10'h001;
    end
  end

  // clock output pin: half-rate square wave of the system clock, low when stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_clock_output_pin <= 1'b0;
      system_clock_output_oe  <= 1'b0;
    end else begin
      system_clock_output_oe <= system_clock_output_pin_enable;
      if (!system_clock_output_pin_enable || stop_mode)
        system_clock_output_pin <= 1'b0;
      else if (sys_pulse)
        system_clock_output_pin <= ~system_clock_output_pin;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_stop_cause;
    $past(stop_mode) || ($past(main_osc_stop_bit) && $past(clock_source_status_bit));
  endsequence
  property p_stop_cause;
    main_osc_stop |-> s_stop_cause;
  endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("main oscillator stopped without cause");
  property p_stop_mode;
    stop_mode |=> main_osc_stop ##0 !osc_en;
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("stop mode left oscillator running");
  property p_through;
    osc_en && !path_pll |=> main_clk_en;
  endproperty
  a_through: assert property (p_through) else $error("clock-through edge lost");
  property p_pll_off;
    !multiplier_run_bit |=> pll_state == PLL_OFF ##1 !pll_use;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("multiplier kept running");
  property p_reset_ctl;
    $rose(aresetn) |-> multiplier_run_bit && !multiplier_path_select;
  endproperty
  a_reset_ctl: assert property (p_reset_ctl) else $error("multiplier control reset wrong");
  property p_sub_sys;
    clock_source_status_bit && sub_en && !stop_mode |=> sys_clk_en;
  endproperty
  a_sub_sys: assert property (p_sub_sys) else $error("subclock pulse missing");
  property p_main_sys;
    sys_clk_en && !$past(clock_source_status_bit, 2) |-> $past(fxx_en);
  endproperty
  a_main_sys: assert property (p_main_sys) else $error("system pulse off main grid");
  property p_div_top;
    periph_clk_en[10] |-> periph_clk_en[0] && periph_clk_en[9] && $past(p1_cnt) == 10'h3FF;
  endproperty
  a_div_top: assert property (p_div_top) else $error("prescaler top tap wrong");
  property p_wdt_src;
    wdt_clk_en[0] |-> $past(osc_en);
  endproperty
  a_wdt_src: assert property (p_wdt_src) else $error("watchdog tap not from oscillator");
  property p_watch_src;
    watch_clk_en |-> $past(osc_en) ##1 !watch_clk_en;
  endproperty
  a_watch_src: assert property (p_watch_src) else $error("watch pulse not from oscillator");
  property p_int_osc;
    int_osc_en |=> !int_osc_en [*8];
  endproperty
  a_int_osc: assert property (p_int_osc) else $error("internal oscillator too fast");
endmodule

// File: hdl/clkgen_consts.svh
// offsets, field positions, reset values and timing counts of the clock generator
// Notes on behaviour
// - clock-through mode passes the 4 to 5 MHz main oscillator unchanged as main clock.
// - PLL mode multiplies the main oscillator by four, giving 16 to 20 MHz.
// - a path-select bit picks clock-through path or multiplied PLL output.
// - a divide-control bit decides whether the four-times multiplication applies.
// - the PLL run bit starts the PLL when set and stops it when cleared.
// - subclock is 32.768 kHz crystal or 20 kHz RC, chosen by a fixed option.
// - an internal oscillator runs at a nominal 200 kHz, independent of resonators.
// - system clock selector offers main clock over 1,2,4,8,16,32 or subclock.
// - main oscillator stops in STOP mode, or on stop bit while subclock runs.
// - prescaler one gives main clock divided by 1 up to 1024 for peripherals.
// - prescaler two gives main clock over 1 to 32 to the CPU/system selector.
// - system clock drives interrupt controller and memories, and the clock-output pin.
// - prescaler three derives 32.768 kHz from the main oscillator for the watch timer.
// - prescaler four divides main oscillator by 1 up to 1024 for the watchdog only.
// - multiplier control resets to 01H; bit 0 runs PLL, bit 1 selects PLL mode.
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH

`define OFS_PROC_CLK_CTRL   8'h00
`define OFS_MULT_CTRL       8'h04
`define OFS_CLK_DIV_CTRL    8'h08
`define OFS_CLK_STATUS      8'h0C
`define OFS_CLK_OUT_CTRL    8'h10

`define PROC_DIV_LSB        0
`define PROC_SUB_BIT        3
`define PROC_STATUS_BIT     4
`define PROC_STOP_BIT       6
`define MULT_RUN_BIT        0
`define MULT_PATH_BIT       1

`define RST_PROC_CLK_CTRL   8'h03
`define RST_MULT_CTRL       8'h01
`define RST_CLK_DIV_CTRL    8'h00

`define ACLK_PERIOD_NS      8
`define INT_OSC_PERIOD_NS   5000
`define INT_OSC_CYCLES      (`INT_OSC_PERIOD_NS / `ACLK_PERIOD_NS)
`define PLL_LOCK_US         800
`define PLL_LOCK_CYCLES     ((`PLL_LOCK_US * 1000) / `ACLK_PERIOD_NS)
`define WATCH_HZ            32768
`define MAIN_OSC_MAX_HZ     5000000
`define MAX_DIV_SEL         3'h5

`endif

// File: hdl/clkgen_pkg.sv
// types shared by the clock generator
package clkgen_pkg;
  typedef enum logic [1:0] {
    PLL_OFF     = 2'b00,
    PLL_LOCKING = 2'b01,
    PLL_LOCKED  = 2'b10
  } pll_state_t;
  typedef logic [1:0] axi_resp_t;
  localparam axi_resp_t RESP_OKAY   = 2'b00;
  localparam axi_resp_t RESP_SLVERR = 2'b10;
endpackage

// File: verification/resonator_model.sv
// behavioural model of the main and sub resonators that drive the oscillator pins
`timescale 1ns/10ps
module resonator_model #(
  parameter int MAIN_HALF_NS = 100,
  parameter int XTAL_HALF_NS = 15259,
  parameter int RC_HALF_NS   = 25000
) (
  // oscillator stop from the block, and the rc option strap
  input  wire logic stop_req,
  input  wire logic rc_option,
  // resonator outputs
  output logic      main_osc,
  output logic      sub_osc
);
  // 5 MHz main resonator, offset so its edges never meet the bus clock edge
  // a stopped oscillator rests low instead of freezing mid-cycle
  initial begin
    main_osc = 1'b0;
    #1;
    forever begin
      #(MAIN_HALF_NS);
      main_osc = stop_req ? 1'b0 : ~main_osc;
    end
  end
  // crystal or rc subclock picked by the strap; it never stops
  initial begin
    sub_osc = 1'b0;
    #3.5;
    forever begin
      #(rc_option ? RC_HALF_NS : XTAL_HALF_NS);
      sub_osc = ~sub_osc;
    end
  end
endmodule

// File: verification/tb_clock_generator_pll_prescalers.sv
// testbench for the clock generator: register access, clock rates and oscillator stop
`timescale 1ns/10ps
module tb_clock_generator_pll_prescalers;
  import clkgen_pkg::*;
  typedef struct {logic [7:0] proc; logic [7:0] mult; logic [7:0] dctl; int mul; int dv;} row_t;
  localparam int WIN   = 3200;
  localparam int OSC_N = WIN / 25;
  logic        aclk      = 1'b0;
  logic        aresetn   = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic        awvalid   = 1'b0;
  logic [31:0] wdata     = 32'h0000_0000;
  logic [3:0]  wstrb     = 4'h0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic [7:0]  araddr    = 8'h00;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        stop_mode = 1'b0;
  logic        halt_mode = 1'b0;
  logic        rc_opt    = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  axi_resp_t   bresp, rresp;
  logic [31:0] rdata, d;
  logic        main_osc_pin, sub_osc_pin, main_osc_stop, main_clk_en, cpu_clk_en, sys_clk_en;
  logic [10:0] periph_clk_en, wdt_clk_en;
  logic        watch_clk_en, int_osc_en, out_pin, out_oe;
  int          mismatches = 0;
  int          checks     = 0;
  int          cnt [9];
  int          exp_main, n;
  row_t        rows [8] = '{
    '{8'h00, 8'h01, 8'h00, 1, 0},  // clock-through, /1
    '{8'h05, 8'h01, 8'h00, 1, 5},  // /32
    '{8'h01, 8'h03, 8'h00, 1, 1},  // multiply disabled by divide control
    '{8'h02, 8'h01, 8'h01, 1, 2},  // path select left at clock-through
    '{8'h04, 8'h03, 8'h01, 4, 4},  // times four, /16
    '{8'h03, 8'h02, 8'h01, 1, 3},  // multiplier stopped
    '{8'h00, 8'h03, 8'h01, 4, 0},  // restarted, must lock again
    '{8'h07, 8'h01, 8'h00, 1, 5}}; // reserved divider code acts as /32
  logic [7:0]  raddr [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
  logic [31:0] rval  [5] = '{32'h0000_0003, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
                             32'h0000_0000};
  axi_resp_t   rrsp  [5] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};

  always #4 aclk = ~aclk;

  resonator_model res (.stop_req(main_osc_stop), .rc_option(rc_opt), .main_osc(main_osc_pin),
                       .sub_osc(sub_osc_pin));

  clock_generator_pll_prescalers #(.LOCK_CYCLES(50), .MAIN_OSC_HZ(5000000)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .main_osc_pin(main_osc_pin), .sub_osc_pin(sub_osc_pin), .sub_osc_rc_option(rc_opt),
    .stop_mode(stop_mode), .halt_mode(halt_mode), .main_osc_stop(main_osc_stop),
    .main_clk_en(main_clk_en), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .periph_clk_en(periph_clk_en), .watch_clk_en(watch_clk_en), .wdt_clk_en(wdt_clk_en),
    .int_osc_en(int_osc_en), .system_clock_output_pin(out_pin),
    .system_clock_output_oe(out_oe));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // counts measured over a window wobble by one pulse at either end
  function automatic logic [31:0] near(input int seen, input int exp, input int tol);
    return (seen - exp <= tol && exp - seen <= tol) ? exp : seen;
  endfunction

  task automatic give_up(input string what);
    mismatches++;
    $display("BAD %s no answer", what);
    complete_run();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    input axi_resp_t er);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 40);
    if (k >= 40) give_up("write");
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input axi_resp_t er);
    int k;
    k = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 40);
    if (k >= 40) give_up("read");
    d = rdata;
    rready <= 1'b0;
    check("rresp", rresp, er);
  endtask

  task automatic measure(input int w);
    logic sub_prev, pin_prev;
    cnt = '{default: 0};
    sub_prev = sub_osc_pin;
    pin_prev = out_pin;
    repeat (w) begin
      @(posedge aclk);
      cnt[0] += int'(main_clk_en === 1'b1);
      cnt[1] += int'(sys_clk_en === 1'b1);
      cnt[2] += int'(cpu_clk_en === 1'b1);
      cnt[3] += int'(periph_clk_en[5] === 1'b1);
      cnt[4] += int'(wdt_clk_en[3] === 1'b1);
      cnt[5] += int'(watch_clk_en === 1'b1);
      cnt[6] += int'(int_osc_en === 1'b1);
      cnt[7] += int'(out_pin !== pin_prev);
      cnt[8] += int'(sub_osc_pin === 1'b1 && sub_prev === 1'b0);
      sub_prev = sub_osc_pin;
      pin_prev = out_pin;
    end
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(8'h04, {24'h00_0000, rows[i].mult}, 4'hF, RESP_OKAY);
      wr(8'h08, {24'h00_0000, rows[i].dctl}, 4'hF, RESP_OKAY);
      wr(8'h00, {24'h00_0000, rows[i].proc}, 4'hF, RESP_OKAY);
      // a divider change waits for the next /32 boundary: up to 800 cycles unmultiplied
      repeat (1000) @(posedge aclk);
      measure(WIN);
      exp_main = OSC_N * rows[i].mul;
      check("main", near(cnt[0], exp_main, 1), exp_main);
      check("sys", near(cnt[1], exp_main >> rows[i].dv, 1), exp_main >> rows[i].dv);
      check("cpu", near(cnt[2], exp_main >> rows[i].dv, 1), exp_main >> rows[i].dv);
      check("periph32", near(cnt[3], exp_main / 32, 1), exp_main / 32);
      check("wdt8", near(cnt[4], OSC_N / 8, 1), OSC_N / 8);
    end
    // second reset in mid-run, then register defaults and bus corner cases
    do_reset();
    foreach (raddr[i]) begin
      rd(raddr[i], rrsp[i]);
      check("reset value", d, rval[i]);
    end
    wr(8'h10, 32'h0000_0001, 4'h0, RESP_OKAY);
    rd(8'h10, RESP_OKAY);
    check("masked store", d, 32'h0000_0000);
    wr(8'h0C, 32'h0000_00FF, 4'hF, RESP_OKAY);
    rd(8'h0C, RESP_OKAY);
    check("status read-only", d & 32'h0000_0009, 32'h0000_0000);
    wr(8'h14, 32'h0000_0001, 4'hF, RESP_SLVERR);
    // clock output and halt at the reset divider of /8
    wr(8'h10, 32'h0000_0001, 4'hF, RESP_OKAY);
    halt_mode <= 1'b1;
    repeat (100) @(posedge aclk);
    measure(WIN);
    check("oe", out_oe, 1'b1);
    check("halt sys", near(cnt[1], OSC_N / 8, 1), OSC_N / 8);
    check("halt cpu", cnt[2], 32'h0000_0000);
    check("pin toggles", near(cnt[7], OSC_N / 8, 1), OSC_N / 8);
    halt_mode <= 1'b0;
    wr(8'h10, 32'h0000_0000, 4'hF, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("oe off", {out_oe, out_pin}, 2'b00);
    measure(20000);
    check("watch", near(cnt[5], 5, 1), 5);
    check("internal osc", near(cnt[6], 32, 1), 32);
    // stop bit is ignored while the main clock is the source
    wr(8'h00, 32'h0000_0043, 4'hF, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("stop ignored", main_osc_stop, 1'b0);
    stop_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    check("stop mode", main_osc_stop, 1'b1);
    stop_mode <= 1'b0;
    // switch to the subclock with the stop bit set
    wr(8'h00, 32'h0000_004B, 4'hF, RESP_OKAY);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (main_osc_stop !== 1'b1 && n < 5000);
    if (n >= 5000) give_up("sub stop");
    check("sub stop", main_osc_stop, 1'b1);
    rd(8'h0C, RESP_OKAY);
    check("status", d & 32'h0000_0009, 32'h0000_0009);
    measure(8000);
    check("sub sys", near(cnt[1], cnt[8], 1), cnt[8]);
    check("main stopped", cnt[0], 32'h0000_0000);
    wr(8'h00, 32'h0000_0003, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("restart", main_osc_stop, 1'b0);
    // rc strap: status shows it once through the synchroniser
    rc_opt <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(8'h0C, RESP_OKAY);
    check("rc option", d & 32'h0000_0002, 32'h0000_0002);
    complete_run();
  end
endmodule
